// ==== verilog/ucc_pkg.sv ====
// package of constants and carrier types for the unprivileged counter bank
package ucc_pkg;
    // ****************************************************************
    // csr numbering
    // ****************************************************************
    localparam logic [11:0] CSR_LOW_BASE   = 12'hC00;  // low halves (full width when 64)
    localparam logic [11:0] CSR_HIGH_BASE  = 12'hC80;  // high halves, 32-bit width only
    localparam int          NUM_SLOTS      = 32;
    localparam int          SLOT_CYCLE     = 0;
    localparam int          SLOT_TIME      = 1;
    localparam int          SLOT_RETIRED   = 2;
    localparam int          FIRST_EVENT    = 3;
    localparam int          COUNTER_WIDTH  = 64;
    localparam logic [63:0] COUNTER_RESET  = 64'h0000_0000_0000_0000;
    localparam logic [63:0] UNIMPL_VALUE   = 64'h0000_0000_0000_0000;

    // ****************************************************************
    // csr instruction function codes
    // ****************************************************************
    localparam logic [2:0] F3_RW  = 3'h1;
    localparam logic [2:0] F3_RS  = 3'h2;
    localparam logic [2:0] F3_RC  = 3'h3;
    localparam logic [2:0] F3_RWI = 3'h5;
    localparam logic [2:0] F3_RSI = 3'h6;
    localparam logic [2:0] F3_RCI = 3'h7;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic        valid;      // one-cycle request
        logic [11:0] csr_num;
        logic [2:0]  funct3;
        logic [4:0]  src;        // source register index or immediate
    } ucc_req_type;

    typedef struct packed {
        logic        valid;      // one cycle after request
        logic        illegal;    // illegal-instruction exception
        logic [63:0] data;
    } ucc_rsp_type;
endpackage : ucc_pkg

// ==== verilog/ucc_counter.sv ====
// one 64-bit wrapping counter with increment enable
`timescale 1ns/1ns
module ucc_counter #(
    parameter int WIDTH = 64
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             inc,
    output logic      [WIDTH-1:0] value
);
    // ****************************************************************
    // count
    // ****************************************************************
    // wraps from all ones to zero by plain modular add
    always_ff @(posedge clk) begin
        if (!nrst) begin
            value <= WIDTH'(ucc_pkg::COUNTER_RESET);
        end else if (inc) begin
            value <= value + WIDTH'(1);
        end
    end
endmodule : ucc_counter

// ==== verilog/ucc_counters.sv ====
// unprivileged counter bank: cycle, wall clock, retired and event counters
`timescale 1ns/1ns
module ucc_counters #(
    parameter int          REGISTER_WIDTH  = 32,
    parameter int          NUM_EVENTS      = 29,
    parameter bit          TIME_FROM_CYCLE = 1'b0,
    parameter bit          UNIMPL_TRAPS    = 1'b1,
    parameter bit          LOW_END         = 1'b0
) (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          core_paused,
    input  wire logic                          rt_tick,
    input  wire logic                          retire_valid,
    input  wire logic                          retire_exception,
    input  wire logic [28:0]                   event_pulse,
    input  wire ucc_pkg::ucc_req_type          req,
    output ucc_pkg::ucc_rsp_type               rsp,
    output logic                               overflow_trap
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // refuse widths and counts that the decode and the slot map cannot serve
    if (REGISTER_WIDTH != 32 && REGISTER_WIDTH != 64) begin : gen_bad_width
        $error("register width must be 32 or 64");
    end
    if (NUM_EVENTS < 0 || NUM_EVENTS > 29) begin : gen_bad_events
        $error("event counter count must be 0 to 29");
    end

    localparam int LAST_SLOT = ucc_pkg::FIRST_EVENT + NUM_EVENTS - 1;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // the tick comes from a separate real-time source; two flops first
    logic       tick_meta;
    logic       tick_sync;
    logic       tick_prev;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
        end else begin
            tick_meta <= rt_tick;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end
    // one increment per rising edge of the shared tick
    logic tick_rise;
    assign tick_rise = tick_sync & ~tick_prev;

    // ****************************************************************
    // counters
    // ****************************************************************
    logic [63:0] slot_value [ucc_pkg::NUM_SLOTS];
    logic [31:0] slot_inc;

    // fixed-function increments: slot 0 cycles, 1 wall clock, 2 retired
    always_comb begin
        slot_inc                       = '0;
        slot_inc[ucc_pkg::SLOT_CYCLE]  = ~core_paused;
        slot_inc[ucc_pkg::SLOT_TIME]   = TIME_FROM_CYCLE ? ~core_paused
                                                         : tick_rise;
        slot_inc[ucc_pkg::SLOT_RETIRED] = retire_valid & ~retire_exception;
        for (int i = 0; i < 29; i++) begin
            slot_inc[ucc_pkg::FIRST_EVENT + i] = event_pulse[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < ucc_pkg::NUM_SLOTS; g++) begin : gen_slot
            if (g <= LAST_SLOT) begin : gen_impl
                ucc_counter #(
                    .WIDTH (ucc_pkg::COUNTER_WIDTH)
                ) u_cnt (
                    .clk   (clk),
                    .nrst  (nrst),
                    .inc   (slot_inc[g]),
                    .value (slot_value[g])
                );
            end else begin : gen_absent
                assign slot_value[g] = ucc_pkg::UNIMPL_VALUE;
            end
        end
    endgenerate

    // ****************************************************************
    // low-end overflow trap
    // ****************************************************************
    // pulses when any implemented low half rolls over, so a handler can
    // keep the high word; full hardware counters remain underneath
    logic [31:0] low_wrap;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            low_wrap[i] = slot_inc[i] && (i <= LAST_SLOT) && (slot_value[i][31:0] == 32'hFFFF_FFFF);
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            overflow_trap <= 1'b0;
        end else begin
            overflow_trap <= LOW_END && (|low_wrap);
        end
    end

    // ****************************************************************
    // csr decode
    // ****************************************************************
    logic       is_low;
    logic       is_high;
    logic [4:0] slot_idx;
    logic       writes;
    logic       known_op;
    always_comb begin
        is_low   = req.csr_num[11:5] == ucc_pkg::CSR_LOW_BASE[11:5];
        is_high  = (REGISTER_WIDTH == 32)
                && (req.csr_num[11:5] == ucc_pkg::CSR_HIGH_BASE[11:5]);
        slot_idx = req.csr_num[4:0];
        known_op = 1'b1;
        writes   = 1'b0;
        unique case (req.funct3)
            ucc_pkg::F3_RW,
            ucc_pkg::F3_RWI: writes = 1'b1;
            ucc_pkg::F3_RS,
            ucc_pkg::F3_RC,
            ucc_pkg::F3_RSI,
            ucc_pkg::F3_RCI: writes = req.src != 5'h00;
            default: known_op = 1'b0;
        endcase
    end

    // ****************************************************************
    // read answer
    // ****************************************************************
    // counters are sampled in the request cycle, before any increment the
    // reading instruction might cause; data lands in a flop next cycle
    logic        next_illegal;
    logic [63:0] next_data;
    logic [63:0] picked;
    always_comb begin
        picked       = slot_value[slot_idx];
        next_illegal = 1'b0;
        next_data    = 64'h0000_0000_0000_0000;
        if (!(is_low || is_high) || !known_op || writes) begin
            next_illegal = 1'b1;
        end else if (UNIMPL_TRAPS && (int'(slot_idx) > LAST_SLOT)) begin
            next_illegal = 1'b1;
        end else if (REGISTER_WIDTH == 64) begin
            next_data = picked;
        end else if (is_high) begin
            next_data = {32'h0000_0000, picked[63:32]};
        end else begin
            next_data = {32'h0000_0000, picked[31:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rsp <= '0;
        end else begin
            rsp.valid   <= req.valid;
            rsp.illegal <= req.valid & next_illegal;
            rsp.data    <= (req.valid && !next_illegal) ? next_data : 64'h0000_0000_0000_0000;
        end
    end
endmodule : ucc_counters

// ==== sim/ucc_counters_sva.sv ====
// checker of the counter bank's csr read port
`timescale 1ns/1ns
module ucc_counters_sva #(
    parameter int REGISTER_WIDTH = 32,
    parameter bit LOW_END        = 1'b0
) (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire ucc_pkg::ucc_req_type req,
    input wire ucc_pkg::ucc_rsp_type rsp,
    input wire logic                 overflow_trap
);
    // ********************
    // decode helpers
    // ********************
    // slot checks assume every event slot is built, as in the default bank
    wire logic in_low  = req.csr_num[11:5] == 7'h60;
    wire logic in_high = req.csr_num[11:5] == 7'h64;
    wire logic set_clr = req.funct3 inside {ucc_pkg::F3_RS, ucc_pkg::F3_RC, ucc_pkg::F3_RSI, ucc_pkg::F3_RCI};
    wire logic rd_ok   = set_clr && req.src == 5'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_write_req;
        req.valid && (req.funct3 == ucc_pkg::F3_RW || req.funct3 == ucc_pkg::F3_RWI);
    endsequence
    sequence s_trap_rsp;
        rsp.valid && rsp.illegal && rsp.data == 64'h0;
    endsequence
    AST_ANSWER_NEXT: assert property (req.valid |=> rsp.valid) else $error("no answer");
    AST_NO_SPURIOUS: assert property (!req.valid |=> !rsp.valid) else $error("stray answer");
    AST_WRITE_TRAPS: assert property (s_write_req |=> s_trap_rsp) else $error("write not trapped");
    AST_SRC_TRAPS: assert property (req.valid && set_clr && req.src != 5'h0 |=> s_trap_rsp)
        else $error("bit write not trapped");
    AST_READ_FORMS: assert property (req.valid && rd_ok && in_low |=> !rsp.illegal)
        else $error("read form refused");
    AST_HIGH_EXISTS: assert property (req.valid && rd_ok && in_high
        |=> rsp.illegal == (REGISTER_WIDTH != 32)) else $error("high half presence wrong");
    AST_OUT_RANGE: assert property (req.valid && !in_low && !in_high |=> s_trap_rsp)
        else $error("unmapped csr answered");
    AST_HIGH_NARROW: assert property (req.valid && in_high ##1 rsp.valid |-> rsp.data[63:32] == 32'h0)
        else $error("high half too wide");
    AST_NO_TRAP: assert property (!LOW_END |-> !overflow_trap) else $error("overflow trap raised");
endmodule : ucc_counters_sva

// ==== sim/ucc_core_model.sv ====
// core pipeline model issuing csr reads to the counter bank
`timescale 1ns/1ns
module ucc_core_model (
    input  wire ucc_pkg::ucc_rsp_type rsp,
    input  wire logic                 clk,
    output ucc_pkg::ucc_req_type      req
);
    // ********************
    // csr access
    // ********************
    initial req = '0;
    // request stands for one edge; idle fields are inverted so stale values never pass
    task automatic access(input logic [11:0] csr, input logic [2:0] f3, input logic [4:0] src,
                          output ucc_pkg::ucc_rsp_type got);
        @(posedge clk);
        req <= '{1'b1, csr, f3, src};
        @(posedge clk);
        req <= '{1'b0, ~csr, ~f3, ~src};
        @(posedge clk);
        got = rsp;
    endtask : access
    // high, low, high again; a carry between the halves forces a retry
    task automatic read64(input logic [4:0] slot, output logic [63:0] val);
        ucc_pkg::ucc_rsp_type hi, lo, hi2;
        do begin
            access(ucc_pkg::CSR_HIGH_BASE + 12'(slot), ucc_pkg::F3_RS, 5'h0, hi);
            access(ucc_pkg::CSR_LOW_BASE + 12'(slot), ucc_pkg::F3_RS, 5'h0, lo);
            access(ucc_pkg::CSR_HIGH_BASE + 12'(slot), ucc_pkg::F3_RS, 5'h0, hi2);
        end while (hi.data !== hi2.data);
        val = {hi.data[31:0], lo.data[31:0]};
    endtask : read64
endmodule : ucc_core_model

// ==== sim/tb_ucc_counters.sv ====
// testbench of the counter bank driven through the core model
`timescale 1ns/1ns
module tb_ucc_counters;
    logic                 clk, nrst, core_paused, rt_tick, retire_valid, retire_exception, overflow_trap;
    logic [28:0]          event_pulse;
    ucc_pkg::ucc_req_type req;
    ucc_pkg::ucc_rsp_type rsp, got;
    logic [63:0]          v0;
    int                   num_errors, samples_checked;
    ucc_counters dut (.clk(clk), .nrst(nrst), .core_paused(core_paused), .rt_tick(rt_tick),
        .retire_valid(retire_valid), .retire_exception(retire_exception), .event_pulse(event_pulse),
        .req(req), .rsp(rsp), .overflow_trap(overflow_trap));
    ucc_core_model core (.clk(clk), .rsp(rsp), .req(req));
    // ********************
    // helpers
    // ********************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic cmp(input logic [63:0] act, input logic [63:0] exp, input string msg);
        samples_checked++;
        if (act !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : cmp
    // low-half read packed as trap flag over 32 data bits
    task automatic rd(input logic [11:0] csr, input logic [2:0] f3, input logic [4:0] src);
        core.access(csr, f3, src, got);
        v0 = {31'h0, got.illegal, got.data[31:0]};
    endtask : rd
    task automatic results;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // ********************
    // scenarios
    // ********************
    // reads three cycles apart step by three, and not at all while paused
    task automatic t_cycle;
        logic [31:0] first;
        for (int p = 0; p < 2; p++) begin
            core_paused <= p[0];
            rd(ucc_pkg::CSR_LOW_BASE, ucc_pkg::F3_RS, 5'h0);
            first = v0[31:0];
            // first read lands two edges after reset release, before its own edge's increment
            if (p == 0) begin
                cmp({32'h0, first}, 64'h1, "cycle after reset");
            end
            rd(ucc_pkg::CSR_LOW_BASE, ucc_pkg::F3_RS, 5'h0);
            cmp({32'h0, v0[31:0] - first}, (p == 0) ? 64'h3 : 64'h0, "cycle step");
        end
        core_paused <= 1'b0;
    endtask : t_cycle
    // three back-to-back retirements, the middle one excepting
    task automatic t_retired;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            retire_valid <= (i < 3);
            retire_exception <= (i == 1);
        end
        core.read64(5'h2, v0);
        cmp(v0, 64'h2, "retired count");
    endtask : t_retired
    // every non-writing form reads; writing forms trap and leave the count alone
    task automatic t_forms;
        logic [2:0] f [4] = '{ucc_pkg::F3_RS, ucc_pkg::F3_RC, ucc_pkg::F3_RSI, ucc_pkg::F3_RCI};
        logic [2:0] w [4] = '{ucc_pkg::F3_RW, ucc_pkg::F3_RWI, ucc_pkg::F3_RS, ucc_pkg::F3_RCI};
        for (int i = 0; i < 4; i++) begin
            rd(12'hC02, f[i], 5'h0);
            cmp(v0, 64'h2, "read form");
            rd(12'hC02, w[i], 5'h1);
            cmp(v0, 64'h1_0000_0000, "write form");
        end
        core.read64(5'h2, v0);
        cmp(v0, 64'h2, "count after writes");
        rd(12'hC02, 3'h0, 5'h0);
        cmp(v0, 64'h1_0000_0000, "unknown op zero");
        rd(12'hC02, 3'h4, 5'h0);
        cmp(v0, 64'h1_0000_0000, "unknown op four");
        rd(12'hC20, ucc_pkg::F3_RS, 5'h0);
        cmp(v0, 64'h1_0000_0000, "unmapped low");
        rd(12'hCA0, ucc_pkg::F3_RS, 5'h0);
        cmp(v0, 64'h1_0000_0000, "unmapped high");
    endtask : t_forms
    // two slow tick rises, each seen once
    task automatic t_time;
        repeat (4) begin
            @(posedge clk);
            rt_tick <= ~rt_tick;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        core.read64(5'h1, v0);
        cmp(v0, 64'h2, "tick count");
    endtask : t_time
    task automatic t_events;
        @(posedge clk);
        event_pulse <= 29'h1;
        repeat (5) @(posedge clk);
        event_pulse <= 29'h1000_0000;
        @(posedge clk);
        event_pulse <= 29'h0;
        core.read64(5'h3, v0);
        cmp(v0, 64'h5, "first event");
        core.read64(5'h1F, v0);
        cmp(v0, 64'h1, "last event");
    endtask : t_events
    initial begin
        {nrst, core_paused, rt_tick, retire_valid, retire_exception} = 5'h0;
        event_pulse = 29'h0;
        num_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_cycle();
        t_retired();
        t_forms();
        t_time();
        t_events();
        results();
    end
    // whole run needs well under a thousand cycles
    initial begin
        #20000;
        num_errors++;
        results();
    end
endmodule : tb_ucc_counters
bind ucc_counters ucc_counters_sva #(.REGISTER_WIDTH(REGISTER_WIDTH), .LOW_END(LOW_END)) u_sva (
    .clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .overflow_trap(overflow_trap));
